// [src/adq_pkg.sv]
// Constants, register map and types for the converter queue and acquisition timer
package adq_pkg;
    // ========================================================================
    // Register bus geometry
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam int SEL_W = 4;

    // ========================================================================
    // Register byte offsets
    localparam logic [4:0] OFS_CTRL_A = 5'h00;
    localparam logic [4:0] OFS_CTRL_B = 5'h04;
    localparam logic [4:0] OFS_CTRL_C = 5'h08;
    localparam logic [4:0] OFS_TRIG_EN = 5'h0C;
    localparam logic [4:0] OFS_RES_LO = 5'h10;
    localparam logic [4:0] OFS_RES_HI = 5'h14;
    localparam logic [4:0] OFS_STATUS = 5'h18;

    // ========================================================================
    // Field positions
    localparam int A_POWER = 0;
    localparam int A_GO = 1;
    localparam int A_LOOP = 2;
    localparam int B_QEN = 0;
    localparam int B_LEFT = 1;
    localparam int B_IVL = 2;
    localparam int B_EMPTY = 4;
    localparam int B_OVF = 5;
    localparam int B_PNT = 6;
    localparam int C_DIV = 0;
    localparam int C_ACQ = 3;
    localparam int ST_IRQ = 0;

    // ========================================================================
    // Sizes, counts and encodings
    localparam int RES_W = 10;
    localparam int QDEPTH = 4;
    localparam int PTR_W = 2;
    localparam int TRIG_W = 5;
    localparam logic [3:0] CONV_TADS = 4'h0C;
    localparam logic [3:0] GAP_TADS = 4'h2;
    localparam logic [3:0] ACQ_NONE = 4'h0;
    localparam logic [1:0] IVL_EVERY1 = 2'h0;
    localparam logic [1:0] IVL_EVERY2 = 2'h1;
    localparam logic [1:0] WCNT_FOURTH = 2'h3;
    localparam logic [8:0] TAD_BASE = 9'h002;
    localparam logic [8:0] TAD_ONE = 9'h001;

    // ========================================================================
    // Types
    typedef enum logic [1:0] {ST_IDLE, ST_ACQ, ST_CONV, ST_GAP} adq_state_e;

    typedef struct packed {
        logic [3:0] acq;
        logic [2:0] div;
    } adq_timing_s;

    typedef struct packed {
        logic qen;
        logic left;
        logic [1:0] ivl;
    } adq_queue_cfg_s;
endpackage

// [src/adq_result_queue.sv]
// Converter control: result queue, acquisition timer and Wishbone register slave
//
// The register addresses and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ns
// ============================================================================
// Overview of operation
// - Four-entry result queue, enabled by control bit
// - Store at write index, then wrap 3 to 0
// - Empty flag set while nothing unread is held
// - Overflow flag on overwrite of unread entry
// - Two-bit read pointer, ignores software writes
// - Interval selects irq on 1, 2, 4 writes
// - Any sequence start forces read pointer to 00
// - Justification picks which byte read advances pointer
// - Go set by software or enabled trigger
// - Nonzero acquisition time samples then converts automatically
// - Zero acquisition time converts at once on go
// - No status separates acquisition end from conversion
// - Single-shot end clears go, sets irq flag
// - Conversion lasts twelve bit periods until stored
// - Two bit period gap, then the next run while go is set, otherwise idle
module adq_result_queue (
    input wire logic CLK,
    input wire logic RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [adq_pkg::ADDR_W-1:0] WB_ADR_I,
    input wire logic [adq_pkg::SEL_W-1:0] WB_SEL_I,
    input wire logic [adq_pkg::DATA_W-1:0] WB_DAT_I,
    output logic [adq_pkg::DATA_W-1:0] WB_DAT_O,
    output logic WB_ACK_O,
    input wire logic [adq_pkg::TRIG_W-1:0] HW_TRIG,
    input wire logic [adq_pkg::RES_W-1:0] SAMPLE_DATA,
    output logic HOLD_ACTIVE,
    output logic CONVERTER_IRQ_FLAG
);
    import adq_pkg::*;

    // ========================================================================
    // State
    adq_state_e state;
    adq_state_e next_state;
    adq_timing_s timing;
    adq_queue_cfg_s qcfg;
    logic converter_power_on;
    logic go;
    logic loop_mode;
    logic [TRIG_W-1:0] trig_en;
    logic [RES_W-1:0] queue_mem [QDEPTH];
    logic [QDEPTH-1:0] unread;
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] queue_read_pointer;
    logic [PTR_W-1:0] wcnt;
    logic queue_overflow_flag;
    logic [7:0] div_cnt;
    logic [3:0] tad_cnt;

    // ========================================================================
    // Bus decode
    wire wb_take = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    wire wr_en = wb_take & WB_WE_I & WB_SEL_I[0];
    wire rd_en = wb_take & ~WB_WE_I;
    wire hit_a = WB_ADR_I == OFS_CTRL_A;
    wire hit_b = WB_ADR_I == OFS_CTRL_B;
    wire hit_c = WB_ADR_I == OFS_CTRL_C;
    wire hit_t = WB_ADR_I == OFS_TRIG_EN;
    wire hit_lo = WB_ADR_I == OFS_RES_LO;
    wire hit_hi = WB_ADR_I == OFS_RES_HI;
    wire hit_s = WB_ADR_I == OFS_STATUS;
    wire wr_a = wr_en & hit_a;

    // ========================================================================
    // Start, abort and bit period timing
    // software go
    wire sw_go = wr_a & WB_DAT_I[A_GO] & ~go & converter_power_on;
    wire trig_go = (|(HW_TRIG & trig_en)) & converter_power_on & ~go & (state == ST_IDLE);
    wire start = sw_go | trig_go;
    // Clearing go or power mid-sequence aborts; the partial result is dropped
    wire abort = wr_a & go & (~WB_DAT_I[A_GO] | ~WB_DAT_I[A_POWER]);
    wire power_off = wr_a & ~WB_DAT_I[A_POWER];
    wire [7:0] tad_top = 8'((TAD_BASE << timing.div) - TAD_ONE);
    wire tad_tick = div_cnt == tad_top;
    wire acq_end = tad_tick & (tad_cnt == timing.acq - 4'h1);
    wire conv_done = (state == ST_CONV) & tad_tick & (tad_cnt == CONV_TADS - 4'h1) & ~abort;
    wire gap_end = (state == ST_GAP) & tad_tick & (tad_cnt == GAP_TADS - 4'h1);
    wire seq_end = conv_done & ~loop_mode;
    // nonzero acquisition time runs a timed sample first
    // zero field goes straight to conversion
    wire acq_zero = timing.acq == ACQ_NONE;
    adq_state_e run_state;
    assign run_state = acq_zero ? ST_CONV : ST_ACQ;

    // Sequencer next state; power loss wins over everything
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (start) begin
                    next_state = run_state;
                end
            end
            ST_ACQ: begin
                if (abort) begin
                    next_state = ST_GAP;
                end else if (acq_end) begin
                    next_state = ST_CONV;
                end
            end
            ST_CONV: begin
                if (abort | conv_done) begin
                    next_state = ST_GAP;
                end
            end
            ST_GAP: begin
                // back to idle, or run again while go is set
                // A go written during the gap is held over and runs here, unless written in the gap's last cycle: go then stays set in idle and never runs
                if (gap_end) begin
                    next_state = go ? run_state : ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (power_off | ~converter_power_on) begin
            next_state = ST_IDLE;
        end
    end

    // Divider and phase counter restart on every phase change
    wire phase_change = next_state != state;
    always_ff @(posedge CLK) begin
        if (RST | phase_change) begin
            div_cnt <= 8'h00;
            tad_cnt <= 4'h0;
        end else if (tad_tick) begin
            div_cnt <= 8'h00;
            tad_cnt <= tad_cnt + 4'h1;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end

    // Sequencer and the hold switch towards the analog side
    // hold drives the front end only, no register reads it
    always_ff @(posedge CLK) begin
        if (RST) begin
            state <= ST_IDLE;
            HOLD_ACTIVE <= 1'b0;
        end else begin
            state <= next_state;
            HOLD_ACTIVE <= next_state == ST_CONV;
        end
    end

    // ========================================================================
    // Control registers
    // single-shot end clears go
    wire next_go = ~(power_off | ~converter_power_on) & (start | (go & ~(seq_end | abort)));
    always_ff @(posedge CLK) begin
        if (RST) begin
            converter_power_on <= 1'b0;
            go <= 1'b0;
            loop_mode <= 1'b0;
            qcfg <= '0;
            timing <= '0;
            trig_en <= '0;
        end else begin
            go <= next_go;
            if (wr_a) begin
                converter_power_on <= WB_DAT_I[A_POWER];
                loop_mode <= WB_DAT_I[A_LOOP];
            end
            // pointer bits of this word are not writable
            if (wr_en & hit_b) begin
                qcfg <= '{WB_DAT_I[B_QEN], WB_DAT_I[B_LEFT], WB_DAT_I[B_IVL+:2]};
            end
            if (wr_en & hit_c) begin
                timing <= '{WB_DAT_I[C_ACQ+:4], WB_DAT_I[C_DIV+:3]};
            end
            if (wr_en & hit_t) begin
                trig_en <= WB_DAT_I[TRIG_W-1:0];
            end
        end
    end

    // ========================================================================
    // Result queue
    // with the queue off everything lands in entry 0
    wire [PTR_W-1:0] wr_idx = qcfg.qen ? wr_ptr : '0;
    wire [PTR_W-1:0] rd_idx = qcfg.qen ? queue_read_pointer : '0;
    // the byte holding eight result bits closes a read: high when left justified, low otherwise
    wire advance = rd_en & (qcfg.left ? hit_hi : hit_lo);
    wire ovf_set = conv_done & unread[wr_idx];
    wire ovf_clr = wr_en & hit_b & WB_DAT_I[B_OVF];
    // empty while no entry is unread
    wire queue_empty_flag = ~|unread;
    wire [RES_W-1:0] res = queue_mem[rd_idx];

    // Per entry storage and unread bits; a store beats a same-cycle read
    genvar gi;
    generate
        for (gi = 0; gi < QDEPTH; gi++) begin : g_entry
            wire set_e = conv_done & (wr_idx == PTR_W'(gi));
            wire clr_e = advance & (rd_idx == PTR_W'(gi));
            always_ff @(posedge CLK) begin
                if (RST) begin
                    unread[gi] <= 1'b0;
                    queue_mem[gi] <= '0;
                end else begin
                    unread[gi] <= set_e | (unread[gi] & ~clr_e);
                    if (set_e) begin
                        queue_mem[gi] <= SAMPLE_DATA;
                    end
                end
            end
        end
    endgenerate

    // Pointers; a new sequence realigns both so reads follow writes
    always_ff @(posedge CLK) begin
        if (RST) begin
            wr_ptr <= '0;
            queue_read_pointer <= '0;
            queue_overflow_flag <= 1'b0;
        end else begin
            if (start) begin
                wr_ptr <= '0;
                queue_read_pointer <= '0;
            end else begin
                // increment wraps 3 to 0 by width
                if (conv_done & qcfg.qen) begin
                    wr_ptr <= wr_ptr + PTR_W'(1);
                end
                if (advance & qcfg.qen) begin
                    queue_read_pointer <= queue_read_pointer + PTR_W'(1);
                end
            end
            queue_overflow_flag <= ovf_set | (queue_overflow_flag & ~ovf_clr);
        end
    end

    // ========================================================================
    // Interrupt flag
    // interval encoding
    wire ivl_hit = (qcfg.ivl == IVL_EVERY1) ? 1'b1 :
                   (qcfg.ivl == IVL_EVERY2) ? wcnt[0] : (wcnt == WCNT_FOURTH);
    // loop mode raises on the selected write count
    wire irq_set = loop_mode ? (conv_done & ivl_hit) : seq_end;
    wire irq_clr = wr_en & hit_s & WB_DAT_I[ST_IRQ];
    always_ff @(posedge CLK) begin
        if (RST) begin
            wcnt <= '0;
            CONVERTER_IRQ_FLAG <= 1'b0;
        end else begin
            if (start) begin
                wcnt <= '0;
            end else if (conv_done) begin
                wcnt <= wcnt + PTR_W'(1);
            end
            // A new event in the clearing cycle is kept
            CONVERTER_IRQ_FLAG <= irq_set | (CONVERTER_IRQ_FLAG & ~irq_clr);
        end
    end

    // ========================================================================
    // Read data and acknowledge
    wire [7:0] res_lo = qcfg.left ? {res[1:0], 6'h00} : res[7:0];
    wire [7:0] res_hi = qcfg.left ? res[9:2] : {6'h00, res[9:8]};
    wire [7:0] rd_a = {5'h00, loop_mode, go, converter_power_on};
    wire [7:0] rd_b = {queue_read_pointer, queue_overflow_flag, queue_empty_flag,
                       qcfg.ivl, qcfg.left, qcfg.qen};
    wire [7:0] rd_c = {1'b0, timing.acq, timing.div};
    wire [7:0] rd_t = {3'h0, trig_en};
    wire [7:0] rd_s = {7'h00, CONVERTER_IRQ_FLAG};
    // Unmapped addresses still acknowledge and read as zero
    wire [7:0] rd_mux = hit_a ? rd_a : hit_b ? rd_b : hit_c ? rd_c : hit_t ? rd_t :
                        hit_lo ? res_lo : hit_hi ? res_hi : hit_s ? rd_s : 8'h00;

    // One wait-free cycle: ack follows the taking edge, then drops
    always_ff @(posedge CLK) begin
        if (RST) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= '0;
        end else begin
            WB_ACK_O <= wb_take;
            if (rd_en) begin
                WB_DAT_O <= {24'h00_0000, rd_mux};
            end
        end
    end
endmodule

// [tb/adq_result_queue_properties.sv]
// Port-level checker for the converter queue and acquisition timer
`timescale 1ns/1ns
module adq_result_queue_properties (
    input wire logic CLK,
    input wire logic RST,
    input wire logic WB_CYC_I,
    input wire logic WB_STB_I,
    input wire logic WB_WE_I,
    input wire logic [adq_pkg::ADDR_W-1:0] WB_ADR_I,
    input wire logic [adq_pkg::SEL_W-1:0] WB_SEL_I,
    input wire logic [adq_pkg::DATA_W-1:0] WB_DAT_I,
    input wire logic [adq_pkg::DATA_W-1:0] WB_DAT_O,
    input wire logic WB_ACK_O,
    input wire logic [adq_pkg::TRIG_W-1:0] HW_TRIG,
    input wire logic [adq_pkg::RES_W-1:0] SAMPLE_DATA,
    input wire logic HOLD_ACTIVE,
    input wire logic CONVERTER_IRQ_FLAG
);
    import adq_pkg::*;
    logic pwr;
    logic [3:0] acq;
    logic [2:0] dv;
    int hcnt;
    // ========================================================================
    // Shadow of power and timing fields, so the bounds follow software
    wire tk = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    wire wr = tk & WB_WE_I & WB_SEL_I[0];
    wire go_wr = wr && WB_ADR_I == OFS_CTRL_A && WB_DAT_I[A_GO] && WB_DAT_I[A_POWER];
    wire start = go_wr && pwr && !HOLD_ACTIVE;
    always_ff @(posedge CLK) begin
        if (RST) begin
            pwr <= 1'b0;
            acq <= 4'h0;
            dv <= 3'h0;
            hcnt <= 0;
        end else begin
            if (wr && WB_ADR_I == OFS_CTRL_A) pwr <= WB_DAT_I[A_POWER];
            if (wr && WB_ADR_I == OFS_CTRL_C) acq <= WB_DAT_I[C_ACQ +: 4];
            if (wr && WB_ADR_I == OFS_CTRL_C) dv <= WB_DAT_I[C_DIV +: 3];
            hcnt <= HOLD_ACTIVE ? hcnt + 1 : 0;
        end
    end
    // ========================================================================
    // Properties
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    property p_ack_next; tk |=> WB_ACK_O; endproperty
    a_ack_next: assert property (p_ack_next)
        else $error("no ack after request");
    property p_ack_pulse; WB_ACK_O |=> !WB_ACK_O; endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("ack longer than one cycle");
    property p_high_zero; WB_ACK_O |-> WB_DAT_O[31:8] == 24'h00_0000; endproperty
    a_high_zero: assert property (p_high_zero)
        else $error("upper read bits not zero");
    property p_unmapped; tk && !WB_WE_I && WB_ADR_I > OFS_STATUS |=> WB_DAT_O == 32'h0000_0000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    // Hold never outlasts twelve bit periods
    property p_hold_bound; HOLD_ACTIVE |-> hcnt < (24 << dv); endproperty
    a_hold_bound: assert property (p_hold_bound)
        else $error("conversion too long");
    property p_irq_store; $rose(CONVERTER_IRQ_FLAG) |-> $fell(HOLD_ACTIVE); endproperty
    a_irq_store: assert property (p_irq_store)
        else $error("irq flag rose without a store");
    property p_start_now; start && acq == ACQ_NONE |-> ##2 HOLD_ACTIVE; endproperty
    a_start_now: assert property (p_start_now)
        else $error("conversion did not start at once");
    property p_start_wait; start && acq != ACQ_NONE |-> ##2 !HOLD_ACTIVE; endproperty
    a_start_wait: assert property (p_start_wait)
        else $error("conversion skipped acquisition");
    c_store: cover property ($fell(HOLD_ACTIVE));
    c_irq: cover property ($rose(CONVERTER_IRQ_FLAG));
    c_acq: cover property (start && acq != ACQ_NONE);
endmodule

// [tb/adq_result_queue_tb_top.sv]
// Self-checking bench for the converter queue and acquisition timer
`timescale 1ns/1ns
module adq_result_queue_tb_top;
    import adq_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [4:0] adr = 5'h00;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] dato;
    logic [31:0] rd;
    logic [31:0] seed = 32'h0000_001B;
    logic [4:0] trig = 5'h00;
    logic [9:0] smp = 10'h000;
    logic [9:0] mem [4];
    logic ack, hold, irq;
    logic hold_q = 1'b0;
    logic trig_on = 1'b0;
    bit abort = 0, irq_m = 0;
    int bad_count = 0, checks = 0, ncyc = 0, hc = 0, wi = 0, n_st = 0, ivl_n = 1, p = 2;
    adq_result_queue dut_u (.CLK(clk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(cyc),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(dat), .WB_DAT_O(dato),
        .WB_ACK_O(ack), .HW_TRIG(trig), .SAMPLE_DATA(smp), .HOLD_ACTIVE(hold),
        .CONVERTER_IRQ_FLAG(irq));
    // ========================================================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Classic single cycle; held until ack, then one idle cycle
    task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        rd = dato;
        cyc <= 1'b0;
        chk("bus ack", 1, ack);
    endtask
    task automatic rdc(input logic [4:0] a, input logic [31:0] e, input string nm);
        wb(1'b0, a, 32'h0000_0000);
        chk(nm, e, rd);
    endtask
    task automatic run(input logic [31:0] c);
        wi = 0;
        n_st = 0;
        repeat (2 * p) @(posedge clk);
        wb(1'b1, OFS_CTRL_A, c);
    endtask
    task automatic clr_irq;
        wb(1'b1, OFS_STATUS, 32'h0000_0001);
        irq_m = 0;
    endtask
    // Completion by polling go, as a host would
    // poll go until clear
    task automatic wait_go;
        int n;
        n = 0;
        rd = 32'h0000_0002;
        while (rd[A_GO] !== 1'b0 && n < 200) begin
            wb(1'b0, OFS_CTRL_A, 32'h0000_0000);
            n++;
        end
        chk("go clears", 0, rd[A_GO]);
    endtask
    // ========================================================================
    // Clock, stimulus noise and timeout
    initial begin
        forever #5 clk = ~clk;
    end
    // Sample frozen while the switch is open, so the stored value is known
    always @(posedge clk) begin
        seed <= xs(seed);
        if (hold !== 1'b1) smp <= seed[9:0];
        trig <= (seed[4:0] & 5'h1B) | (trig_on ? 5'h04 : 5'h00);
        ncyc <= ncyc + 1;
        if (ncyc == 20000) begin
            bad_count++;
            summarize();
        end
    end
    // Store model: conversion length, queue contents, sticky irq by interval
    always @(negedge clk) begin
        if (hold === 1'b1) hc++;
        if (hold_q === 1'b1 && hold === 1'b0) begin
            if (!abort) begin
                chk("hold length", 12 * p, hc);
                mem[wi] = smp;
                wi = (wi + 1) % 4;
                n_st++;
                if (n_st % ivl_n == 0) irq_m = 1;
                chk("irq at store", irq_m, irq);
            end
            hc = 0;
        end
        hold_q = hold;
    end
    // ========================================================================
    // Main sequence
    initial begin
        int n;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rdc(OFS_CTRL_B, 32'h0000_0010, "empty at reset");
        rdc(5'h1C, 32'h0000_0000, "unmapped read");
        wb(1'b1, OFS_CTRL_B, 32'h0000_00C1);
        rdc(OFS_CTRL_B, 32'h0000_0011, "pointer read-only");
        clr_irq();
        wb(1'b1, OFS_CTRL_A, 32'h0000_0001);
        repeat (500) @(posedge clk);
        run(32'h0000_0003);
        wait_go();
        rdc(OFS_RES_HI, {22'h0, mem[0][9:8]}, "high byte");
        rdc(OFS_RES_LO, {24'h0, mem[0][7:0]}, "low byte");
        rdc(OFS_CTRL_B, 32'h0000_0051, "pointer after read");
        $display("test single shot done");
        // Continuous mode for every interval code, five stores to force a wrap
        for (int c = 0; c < 4; c++) begin
            wb(1'b1, OFS_CTRL_B, 32'h0000_0021 | (c << 2));
            clr_irq();
            ivl_n = (c == 0) ? 1 : (c == 1) ? 2 : 4;
            run(32'h0000_0007);
            n = 0;
            while (n_st < 5 && n < 2000) begin
                @(negedge clk);
                n++;
            end
            abort = 1;
            wb(1'b1, OFS_CTRL_A, 32'h0000_0001);
            repeat (10) @(posedge clk);
            abort = 0;
            rdc(OFS_CTRL_B, 32'h0000_0021 | (c << 2), "overflow");
            for (int k = 0; k < 4; k++) begin
                rdc(OFS_RES_HI, {22'h0, mem[k][9:8]}, "queue high");
                rdc(OFS_RES_LO, {24'h0, mem[k][7:0]}, "queue low");
            end
            rdc(OFS_CTRL_B, 32'h0000_0031 | (c << 2), "drained");
        end
        $display("test interval codes done");
        // Three bit periods of four clocks must pass before the hold
        wb(1'b1, OFS_CTRL_C, 32'h0000_0019);
        p = 4;
        ivl_n = 1;
        clr_irq();
        run(32'h0000_0003);
        #1;
        // The ack edge already lies one clock after the start edge
        n = 1;
        while (hold !== 1'b1 && n < 100) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("acquisition delay", 12, n);
        wait_go();
        $display("test acquisition done");
        // Abort mid conversion leaves no store and no flag
        wb(1'b1, OFS_CTRL_C, 32'h0000_0000);
        p = 2;
        clr_irq();
        run(32'h0000_0003);
        repeat (6) @(posedge clk);
        abort = 1;
        wb(1'b1, OFS_CTRL_A, 32'h0000_0001);
        repeat (8) @(posedge clk);
        abort = 0;
        chk("irq after abort", 0, irq);
        chk("hold after abort", 0, hold);
        $display("test abort done");
        // Left justified readout, then a hardware triggered start
        wb(1'b1, OFS_CTRL_B, 32'h0000_0023);
        rdc(OFS_RES_HI, {24'h0, mem[0][9:2]}, "left high");
        wb(1'b1, OFS_TRIG_EN, 32'h0000_0004);
        wi = 0;
        n_st = 0;
        @(posedge clk);
        trig_on <= 1'b1;
        @(posedge clk);
        trig_on <= 1'b0;
        rdc(OFS_CTRL_A, 32'h0000_0003, "go set by trigger");
        wait_go();
        rdc(OFS_CTRL_B, 32'h0000_0003, "pointer reset by start");
        rdc(OFS_RES_LO, {24'h0, mem[0][1:0], 6'h00}, "left low");
        rdc(OFS_RES_HI, {24'h0, mem[0][9:2]}, "left high");
        $display("test trigger done");
        // Queue off: every store and read uses entry zero, the start clears the pointer and reads do not advance it
        wb(1'b1, OFS_CTRL_B, 32'h0000_0020);
        run(32'h0000_0003);
        wait_go();
        rdc(OFS_RES_LO, {24'h0, mem[0][7:0]}, "queue off low");
        rdc(OFS_CTRL_B, 32'h0000_0010, "queue off pointer");
        $display("test queue off done");
        summarize();
    end
endmodule
bind adq_result_queue adq_result_queue_properties chk_u (.CLK(CLK), .RST(RST),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
    .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .HW_TRIG(HW_TRIG), .SAMPLE_DATA(SAMPLE_DATA), .HOLD_ACTIVE(HOLD_ACTIVE),
    .CONVERTER_IRQ_FLAG(CONVERTER_IRQ_FLAG));
